/* logic/pbc_consts.svh */
// Constants for the pump and blower control logic: register map, field
// positions, reset values and timing counts.
// Assumes a 250 MHz pclk; the tick and debounce times are converted into cycle counts here, the others into milliseconds.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// ****************************************************************
// Register map (byte addresses).
// ****************************************************************
`define PBC_ADDR_CTRL     8'h00
`define PBC_ADDR_STATUS   8'h04
`define PBC_ADDR_LAMPS    8'h08
`define PBC_CTRL_RESET    3'h0
`define PBC_CTRL_W        3

// ****************************************************************
// Control register fields.
// ****************************************************************
`define PBC_CTRL_PRESS_ILK 0
`define PBC_CTRL_SUMP_BLOW 1
`define PBC_CTRL_SUMP_PUMP 2

// ****************************************************************
// Timing.
// ****************************************************************
`define PBC_CLK_HZ        250000000
`define PBC_MS_PER_S      1000
`define PBC_TICK_CYC      (`PBC_CLK_HZ / `PBC_MS_PER_S)
`define PBC_HIPRESS_S     180
`define PBC_HIPRESS_MS    (`PBC_HIPRESS_S * `PBC_MS_PER_S)
`define PBC_JUMPER_S      7
`define PBC_JUMPER_MS     (`PBC_JUMPER_S * `PBC_MS_PER_S)
`define PBC_GRACE_S       5
`define PBC_GRACE_MS      (`PBC_GRACE_S * `PBC_MS_PER_S)
`define PBC_SLOW_HALF_MS  500
`define PBC_FAST_HALF_MS  125
`define PBC_DEBOUNCE_MS   20
`define PBC_DEBOUNCE_CYC  (`PBC_DEBOUNCE_MS * `PBC_TICK_CYC)

`endif

/* logic/pbc_pkg.sv */
// Types shared by the pump and blower control logic.
// Assumes pbc_consts.svh supplies the numeric constants.
package pbc_pkg;

  // Selector state, one-hot.
  typedef enum logic [3:0] {
    PBC_SEL_OFF  = 4'h1,
    PBC_SEL_A    = 4'h2,
    PBC_SEL_B    = 4'h4,
    PBC_SEL_FAIL = 4'h8
  } pbc_sel_e;

  // Field inputs: selector contacts and sensors.
  typedef struct packed {
    logic pump_hand;
    logic pump_auto;
    logic blow_run;
    logic blow_reset;
    logic level_float_hi;
    logic level_float_lo;
    logic backup_float_ok;
    logic press_hi;
    logic press_lo;
    logic thermal;
    logic sump_high;
    logic jumper;
  } pbc_field_s;

  // Faceplate lamps.
  typedef struct packed {
    logic fault;
    logic modem_call_lamp;
    logic auto_lamp;
    logic pump_running;
    logic blow_run_lamp;
    logic blow_running;
    logic probe_high;
    logic probe_low;
    logic backup_float_trip;
    logic thermal;
    logic pressure;
    logic sump;
    logic interlock_alarm_lamp;
  } pbc_lamp_s;

endpackage

/* logic/pbc_top.sv */
// Pump and blower control logic with an APB register slave.
// Assumes field inputs are asynchronous pins and the status inputs come
// from logic on pclk.
//
// Operation
// RULE_01 - Flash the fault lamp while self-test reports an error.
// RULE_02 - Call lamp steady during a modem call, blinking on telemetry fault.
// RULE_03 - Pump selector hand: pump relay on, level inputs ignored.
// RULE_04 - Auto: start pump on high float, run until low float.
// RULE_05 - Auto: backup float drop opens the pump relay at once.
// RULE_06 - Backup trip latches pump off, lamp on, until off then auto.
// RULE_07 - Pump selector off: relay open, probe lamps dark.
// RULE_08 - Auto lamp lit in auto, blinking on selector failure.
// RULE_09 - Running lamps follow pump and blower relays.
// RULE_10 - High lamp while float top or descending, low lamp otherwise.
// RULE_11 - Lamps in hand or auto work regardless of pump breaker.
// RULE_12 - Blower run: relay closed unless pressure or thermal fault.
// RULE_13 - Sump level watched in run and off; stops blower if interlocked.
// RULE_14 - Blower reset position clears thermal, sump and pressure latches.
// RULE_15 - Reset held while pump toggles: clear command, fast alarm blink.
// RULE_16 - Blower run lamp lit in run, blinking on selector failure.
// RULE_17 - Thermal shutdown lights thermal lamp until reset.
// RULE_18 - Pressure lights lamp, stops blower, stops pump if interlocked.
// RULE_19 - Low pressure blinks and stops now; high pressure steady, 3 min.
// RULE_20 - Jumper shortens the high pressure delay to seven seconds.
// RULE_21 - Pressure inputs ignored for five seconds after blower start.
// RULE_22 - Sump lamp on sump input; motors stop only if interlocked.
// RULE_23 - Blink rates and debounce are counted clock parameters.
`include "pbc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pbc_top #(
  parameter int unsigned DEBOUNCE_CYC = `PBC_DEBOUNCE_CYC,
  parameter int unsigned TICK_CYC     = `PBC_TICK_CYC,
  parameter int unsigned HIPRESS_MS   = `PBC_HIPRESS_MS,
  parameter int unsigned JUMPER_MS    = `PBC_JUMPER_MS,
  parameter int unsigned GRACE_MS     = `PBC_GRACE_MS
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire pbc_pkg::pbc_field_s field_in,
  input  wire logic               selftest_err,
  input  wire logic               modem_busy,
  input  wire logic               tele_fault,
  input  wire logic               clear_done,
  output logic                    pump_relay,
  output logic                    blower_relay,
  output logic                    clear_cmd,
  output pbc_pkg::pbc_lamp_s      lamps
);

  localparam int NIN = $bits(pbc_pkg::pbc_field_s);

  // ****************************************************************
  // Helper function.
  // ****************************************************************

  // Decodes a two-contact selector; both contacts closed is a failure.
  function automatic pbc_pkg::pbc_sel_e sel_decode(input logic a,
                                                   input logic b);
    if (a && b)
      sel_decode = pbc_pkg::PBC_SEL_FAIL;
    else if (a)
      sel_decode = pbc_pkg::PBC_SEL_A;
    else if (b)
      sel_decode = pbc_pkg::PBC_SEL_B;
    else
      sel_decode = pbc_pkg::PBC_SEL_OFF;
  endfunction

  // ****************************************************************
  // Input synchronisers and debouncers.
  // ****************************************************************
  logic [NIN-1:0]    sync1;
  logic [NIN-1:0]    sync2;
  logic [NIN-1:0]    stable;
  pbc_pkg::pbc_field_s in;

  // Two flip-flops bring the pins onto pclk.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= field_in;
      sync2 <= sync1;
    end

  // Each input must hold a new level for DEBOUNCE_CYC cycles.
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_deb
      logic [31:0] cnt;
      logic        lvl;
      // Each bit keeps its own level so only one process drives it.
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
          cnt <= '0;
          lvl <= 1'b0;
        end
        else if (sync2[gi] == lvl)
          cnt <= '0;
        else if (cnt >= DEBOUNCE_CYC - 1) // RULE_23
        begin
          cnt <= '0;
          lvl <= sync2[gi];
        end
        else
          cnt <= cnt + 32'h1;
      assign stable[gi] = lvl;
    end
  endgenerate
  assign in = stable;

  // ****************************************************************
  // Millisecond tick and blink phases.
  // ****************************************************************
  logic [31:0] tick_cnt;
  logic        tick;
  logic [15:0] slow_cnt;
  logic [15:0] fast_cnt;
  logic        slow_ph;
  logic        fast_ph;

  // Divides pclk to a 1 ms tick and toggles two blink phases.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
      slow_cnt <= '0;
      fast_cnt <= '0;
      slow_ph <= 1'b0;
      fast_ph <= 1'b0;
    end
    else
    begin
      tick <= (tick_cnt >= TICK_CYC - 1);
      tick_cnt <= (tick_cnt >= TICK_CYC - 1) ? '0 : tick_cnt + 32'h1;
      if (tick)
      begin
        slow_cnt <= (slow_cnt >= `PBC_SLOW_HALF_MS - 1) ? '0
                    : slow_cnt + 16'h1;
        fast_cnt <= (fast_cnt >= `PBC_FAST_HALF_MS - 1) ? '0
                    : fast_cnt + 16'h1;
        if (slow_cnt >= `PBC_SLOW_HALF_MS - 1)
          slow_ph <= ~slow_ph; // RULE_23
        if (fast_cnt >= `PBC_FAST_HALF_MS - 1)
          fast_ph <= ~fast_ph; // RULE_23
      end
    end

  // ****************************************************************
  // APB register slave.
  // ****************************************************************
  logic [`PBC_CTRL_W-1:0] ctrl;
  logic [31:0]            status_word;
  logic                   hit;

  // Answers one cycle after the access phase opens; unmapped or
  // read-only writes end with pslverr.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl <= `PBC_CTRL_RESET;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && penable && !pready)
      begin
        case (paddr)
          `PBC_ADDR_CTRL:
            if (pwrite)
              ctrl <= pwdata[`PBC_CTRL_W-1:0];
            else
              prdata <= {29'h0, ctrl};
          `PBC_ADDR_STATUS:
            if (pwrite)
              pslverr <= 1'b1;
            else
              prdata <= status_word;
          `PBC_ADDR_LAMPS:
            if (pwrite)
              pslverr <= 1'b1;
            else
              prdata <= {19'h0, lamps};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end

  // ****************************************************************
  // Pump control.
  // ****************************************************************
  pbc_pkg::pbc_sel_e pump_sel;
  pbc_pkg::pbc_sel_e blow_sel;
  pbc_pkg::pbc_sel_e prev_pump;
  logic              pump_run;
  logic              trip;
  logic              press_stop;
  logic              press_lo_lat;
  logic              hp_seen;
  logic              sump_lat;
  logic              therm_lat;
  logic              pump_ilk;
  logic              next_pump_relay;

  assign pump_sel = sel_decode(in.pump_hand, in.pump_auto);
  assign blow_sel = sel_decode(in.blow_reset, in.blow_run);
  assign pump_ilk = (ctrl[`PBC_CTRL_PRESS_ILK] && (press_stop || press_lo_lat))
                 || (ctrl[`PBC_CTRL_SUMP_PUMP] && sump_lat);

  // Level hysteresis, tracked in hand and auto so the probe lamps work.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pump_run <= 1'b0;
    else if (pump_sel == pbc_pkg::PBC_SEL_OFF)
      pump_run <= 1'b0;
    else if (in.level_float_hi)
      pump_run <= 1'b1; // RULE_04
    else if (in.level_float_lo)
      pump_run <= 1'b0; // RULE_04

  // Backup float trip holds until the selector visits off.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      trip <= 1'b0;
    else if (pump_sel == pbc_pkg::PBC_SEL_B && !in.backup_float_ok)
      trip <= 1'b1; // RULE_06
    else if (pump_sel == pbc_pkg::PBC_SEL_OFF)
      trip <= 1'b0; // RULE_06

  // Pump relay from selector, level latch, trip and interlocks.
  always_comb
  begin
    case (pump_sel)
      pbc_pkg::PBC_SEL_A:
        next_pump_relay = 1'b1; // RULE_03
      pbc_pkg::PBC_SEL_B:
        next_pump_relay = pump_run && in.backup_float_ok && !trip
                       && !pump_ilk; // RULE_05 RULE_18 RULE_22
      pbc_pkg::PBC_SEL_OFF:
        next_pump_relay = 1'b0; // RULE_07
      default:
        next_pump_relay = 1'b0;
    endcase
  end

  // ****************************************************************
  // Blower control.
  // ****************************************************************
  logic [31:0] start_ms;
  logic [31:0] hp_ms;
  logic        grace_done;
  logic        next_blower_relay;

  assign grace_done = blower_relay && (start_ms >= GRACE_MS);

  // Counts blower run time and high pressure time in milliseconds.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      start_ms <= '0;
      hp_ms <= '0;
    end
    else
    begin
      if (!blower_relay)
        start_ms <= '0;
      else if (tick && !grace_done)
        start_ms <= start_ms + 32'h1; // RULE_21
      if (!(in.press_hi && grace_done))
        hp_ms <= '0;
      else if (tick)
        hp_ms <= hp_ms + 32'h1;
    end

  // Fault latches; a set beats the clear in one cycle, but each set needs the blower running or the selector in run or off.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      press_lo_lat <= 1'b0;
      hp_seen <= 1'b0;
      press_stop <= 1'b0;
      therm_lat <= 1'b0;
      sump_lat <= 1'b0;
    end
    else
    begin
      if (in.press_lo && grace_done)
        press_lo_lat <= 1'b1; // RULE_19 RULE_21
      else if (blow_sel == pbc_pkg::PBC_SEL_A)
        press_lo_lat <= 1'b0; // RULE_14
      if (in.press_hi && grace_done)
        hp_seen <= 1'b1; // RULE_19
      else if (blow_sel == pbc_pkg::PBC_SEL_A)
        hp_seen <= 1'b0; // RULE_14
      if (in.press_hi && grace_done
          && hp_ms >= (in.jumper ? JUMPER_MS : HIPRESS_MS))
        press_stop <= 1'b1; // RULE_19 RULE_20
      else if (blow_sel == pbc_pkg::PBC_SEL_A)
        press_stop <= 1'b0; // RULE_14
      if (in.thermal && blower_relay)
        therm_lat <= 1'b1; // RULE_17
      else if (blow_sel == pbc_pkg::PBC_SEL_A)
        therm_lat <= 1'b0; // RULE_14
      if (in.sump_high && (blow_sel == pbc_pkg::PBC_SEL_B
                        || blow_sel == pbc_pkg::PBC_SEL_OFF))
        sump_lat <= 1'b1; // RULE_13 RULE_22
      else if (blow_sel == pbc_pkg::PBC_SEL_A)
        sump_lat <= 1'b0; // RULE_14
    end

  // Blower relay closed in run unless a latched fault stops it.
  assign next_blower_relay = (blow_sel == pbc_pkg::PBC_SEL_B)
    && !therm_lat && !press_lo_lat && !press_stop
    && !(ctrl[`PBC_CTRL_SUMP_BLOW] && sump_lat); // RULE_12 RULE_13

  // ****************************************************************
  // Clear interlocks sequence.
  // ****************************************************************
  logic clearing;

  // Reset held while the pump selector goes auto to hand issues a clear.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prev_pump <= pbc_pkg::PBC_SEL_OFF;
      clear_cmd <= 1'b0;
      clearing <= 1'b0;
    end
    else
    begin
      prev_pump <= pump_sel;
      clear_cmd <= 1'b0;
      if (blow_sel == pbc_pkg::PBC_SEL_A && prev_pump == pbc_pkg::PBC_SEL_B
          && pump_sel == pbc_pkg::PBC_SEL_A)
      begin
        clear_cmd <= 1'b1; // RULE_15
        clearing <= 1'b1; // RULE_15
      end
      else if (clear_done)
        clearing <= 1'b0; // RULE_15
    end

  // ****************************************************************
  // Relay and lamp outputs.
  // ****************************************************************
  logic local_alarm;
  assign local_alarm = press_lo_lat || press_stop || sump_lat;

  // All outputs are registered; lamps ignore the breakers.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pump_relay <= 1'b0;
      blower_relay <= 1'b0;
      lamps <= '0;
    end
    else
    begin
      pump_relay <= next_pump_relay;
      blower_relay <= next_blower_relay;
      lamps.fault <= selftest_err && slow_ph; // RULE_01
      lamps.modem_call_lamp <= tele_fault ? slow_ph : modem_busy; // RULE_02
      lamps.auto_lamp <= (pump_sel == pbc_pkg::PBC_SEL_B)
        || (pump_sel == pbc_pkg::PBC_SEL_FAIL && slow_ph); // RULE_08 RULE_11
      lamps.pump_running <= next_pump_relay; // RULE_09 RULE_11
      lamps.blow_run_lamp <= (blow_sel == pbc_pkg::PBC_SEL_B)
        || (blow_sel == pbc_pkg::PBC_SEL_FAIL && slow_ph); // RULE_16
      lamps.blow_running <= next_blower_relay; // RULE_09
      lamps.probe_high <= (pump_sel == pbc_pkg::PBC_SEL_A
        || pump_sel == pbc_pkg::PBC_SEL_B) && pump_run; // RULE_10 RULE_07
      lamps.probe_low <= (pump_sel == pbc_pkg::PBC_SEL_A
        || pump_sel == pbc_pkg::PBC_SEL_B) && !pump_run; // RULE_10 RULE_07
      lamps.backup_float_trip <= trip; // RULE_06
      lamps.thermal <= therm_lat; // RULE_17
      lamps.pressure <= press_lo_lat ? slow_ph : hp_seen; // RULE_18 RULE_19
      lamps.sump <= sump_lat; // RULE_22
      lamps.interlock_alarm_lamp <= clearing ? fast_ph
        : (local_alarm && slow_ph); // RULE_15
    end

  assign status_word = {22'h0, clearing, sump_lat, therm_lat, press_stop,
                        hp_seen, press_lo_lat, trip, pump_run, blower_relay,
                        pump_relay};

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  AST_HAND_RELAY: assert property (@(posedge pclk) disable iff (!presetn)
    pump_sel == pbc_pkg::PBC_SEL_A |=> pump_relay) // RULE_03
    else $error("Pump relay open in hand.");
  AST_OFF_DARK: assert property (@(posedge pclk) disable iff (!presetn)
    pump_sel == pbc_pkg::PBC_SEL_OFF |=> !pump_relay && !lamps.probe_high
    && !lamps.probe_low) // RULE_07
    else $error("Pump or probe lamps active in off.");
  AST_BACKUP_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
    pump_sel == pbc_pkg::PBC_SEL_B && !in.backup_float_ok
    |=> !pump_relay ##1 lamps.backup_float_trip) // RULE_05
    else $error("Backup float drop did not trip the pump.");
  AST_TRIP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    trip && pump_sel != pbc_pkg::PBC_SEL_OFF |=> trip) // RULE_06
    else $error("Backup trip released without off.");
  AST_RUN_LAMPS: assert property (@(posedge pclk) disable iff (!presetn)
    lamps.pump_running == pump_relay
    && lamps.blow_running == blower_relay) // RULE_09
    else $error("Running lamp disagrees with relay.");
  AST_GRACE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(press_lo_lat) |-> $past(grace_done)) // RULE_21
    else $error("Pressure fault taken during start grace.");
  AST_LOWP_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    press_lo_lat |=> !blower_relay) // RULE_19
    else $error("Blower runs after low pressure.");
  AST_THERM_LAMP: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(therm_lat) |=> lamps.thermal && !blower_relay) // RULE_17
    else $error("Thermal lamp or stop missing.");
  AST_CLEAR_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    clear_cmd |-> clearing ##1 !clear_cmd) // RULE_15
    else $error("Clear command not a single pulse.");

endmodule

`default_nettype wire

/* verif/pbc_field_model.sv */
// Model of the operator switches, level probe and field sensors.
// Assumes the bench sets positions and levels just after rising edges.
`timescale 1ns/1ps
`default_nettype none

module pbc_field_model (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [1:0]    pump_pos,
  input  wire logic [1:0]    blow_pos,
  input  wire logic [1:0]    level,
  input  wire logic [5:0]    sens,
  input  wire logic          clear_cmd,
  input  wire logic [11:0]   clear_wait,
  output var logic           clear_done,
  output var pbc_pkg::pbc_field_s field_in
);
  logic [11:0] wait_cnt;
  logic        busy;

  // Position 3 is a broken switch with both contacts closed; the float
  // closes the top or bottom contact, or neither while travelling.
  always_comb
  begin
    field_in = {pump_pos[0], pump_pos[1],
                blow_pos[0], blow_pos[1],
                level == 2'h2, level == 2'h0, sens};
  end

  // Clearing takes clear_wait cycles, then done pulses for one cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy       <= 1'b0;
      wait_cnt   <= 12'h000;
      clear_done <= 1'b0;
    end
    else
    begin
      clear_done <= busy && wait_cnt == 12'h000;
      if (clear_cmd)
      begin
        busy     <= 1'b1;
        wait_cnt <= clear_wait;
      end
      else if (wait_cnt != 12'h000)
        wait_cnt <= wait_cnt - 12'h001;
      else
        busy <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the pump and blower control logic.
// Assumes pbc_top with shortened counts and the field model beside it.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  pbc_pkg::pbc_field_s field_in;
  pbc_pkg::pbc_lamp_s  lamps;
  logic [12:0]         lv;
  logic [2:0]          st = 3'h0;
  logic                clear_done;
  logic                pump_relay;
  logic                blower_relay;
  logic                clear_cmd;
  logic [1:0]          pump_pos = 2'h0;
  logic [1:0]          blow_pos = 2'h0;
  logic [1:0]          level = 2'h0;
  logic [5:0]          sens = 6'h20;
  logic [11:0]         clear_wait = 12'h9c4;
  logic [31:0]         rd;
  logic                err;
  logic                e;
  logic [1:0]          m;
  logic [3:0]          x;
  int                  n_mismatch = 0;
  int                  n_checks = 0;
  int                  seed = 32'h056a;
  int                  k;

  assign lv = lamps;

  // Clock of 4 ns.
  always #2 pclk = ~pclk;

  pbc_top #(.DEBOUNCE_CYC(4), .TICK_CYC(4), .HIPRESS_MS(20),
            .JUMPER_MS(5), .GRACE_MS(3)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .field_in(field_in),
    .selftest_err(st[2]), .modem_busy(st[1]), .tele_fault(st[0]),
    .clear_done(clear_done), .pump_relay(pump_relay),
    .blower_relay(blower_relay), .clear_cmd(clear_cmd), .lamps(lamps));

  pbc_field_model field (
    .pclk(pclk), .presetn(presetn), .pump_pos(pump_pos),
    .blow_pos(blow_pos), .level(level), .sens(sens),
    .clear_cmd(clear_cmd), .clear_wait(clear_wait),
    .clear_done(clear_done), .field_in(field_in));

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
    begin
      n_mismatch++;
      test_done();
    end
  endtask

  // Covers the synchroniser, debounce and output register latency.
  task automatic settle();
    repeat (12) @(posedge pclk);
  endtask

  // Classifies a lamp over n cycles: 0 dark, 1 blinking, 2 steady.
  task automatic watch(input int idx, input int n);
    int ones;
    ones = 0;
    repeat (n)
    begin
      @(posedge pclk);
      ones += (lv[idx] === 1'b1);
    end
    m = (ones == 0) ? 2'h0 : (ones == n) ? 2'h2 : 2'h1;
  endtask

  // Passes the blower selector through reset and back to run.
  task automatic reset_blow();
    blow_pos <= 2'h2;
    settle();
    blow_pos <= 2'h1;
    settle();
  endtask

  // Main sequence of scenarios.
  initial
  begin
    repeat (3) @(posedge pclk);
    chk("reset", 32'({pump_relay, blower_relay, clear_cmd, lv}), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    k = $random(seed);
    apb(1'b1, 8'h00, 32'(k));
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl readback", rd, 32'(k[2:0]));
    apb(1'b1, 8'h0c, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    chk("read only", 32'(err), 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    level <= 2'h2;
    settle();
    chk("pump off", 32'({pump_relay, lv[6], lv[5]}), 32'h0);
    pump_pos <= 2'h1;
    level <= 2'h0;
    settle();
    chk("hand", 32'({pump_relay, lv[9]}), 32'h3);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", rd, 32'h1);
    chk("read err", 32'(err), 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("lamp reg", rd, 32'h220);
    pump_pos <= 2'h2;
    for (int i = 0; i < 6; i++)
    begin
      level <= (i % 2 == 1) ? 2'h1 : 2'(i % 4);
      e = (i == 2 || i == 3);
      settle();
      k = $random(seed) & 7;
      repeat (k) @(posedge pclk);
      x = {pump_relay, lv[10], lv[6], lv[5]};
      chk("auto", 32'(x), 32'({e, 1'b1, e, !e}));
    end
    level <= 2'h2;
    settle();
    sens[5] <= 1'b0;
    settle();
    chk("backup", 32'({pump_relay, lv[4]}), 32'h1);
    sens[5] <= 1'b1;
    settle();
    chk("backup held", 32'({pump_relay, lv[4]}), 32'h1);
    pump_pos <= 2'h0;
    settle();
    pump_pos <= 2'h2;
    settle();
    chk("backup reset", 32'({pump_relay, lv[4]}), 32'h2);
    blow_pos <= 2'h1;
    sens[3] <= 1'b1;
    repeat (14) @(posedge pclk);
    x = {1'b0, blower_relay, lv[8], lv[7]};
    chk("grace", 32'(x), 32'h7);
    repeat (40) @(posedge pclk);
    chk("low press", 32'({blower_relay, pump_relay}), 32'h0);
    watch(2, 4200);
    chk("press blink", 32'(m), 32'h1);
    sens[3] <= 1'b0;
    reset_blow();
    x = {1'b0, blower_relay, pump_relay, lv[2]};
    chk("press clear", 32'(x), 32'h6);
    for (int j = 0; j < 2; j++)
    begin
      sens <= {3'b110, 2'b00, 1'(j)};
      settle();
      chk("hi delay", 32'(blower_relay), 32'h1);
      repeat (j ? 28 : 88) @(posedge pclk);
      x = {1'b0, blower_relay, pump_relay, lv[2]};
      chk("hi stop", 32'(x), 32'h1);
      watch(2, 200);
      chk("hi steady", 32'(m), 32'h2);
      sens <= 6'h20;
      reset_blow();
    end
    sens[2] <= 1'b1;
    settle();
    sens[2] <= 1'b0;
    settle();
    chk("thermal", 32'({blower_relay, lv[3]}), 32'h1);
    reset_blow();
    chk("thermal clr", 32'({blower_relay, lv[3]}), 32'h2);
    apb(1'b1, 8'h00, 32'h0);
    sens[1] <= 1'b1;
    settle();
    x = {1'b0, blower_relay, pump_relay, lv[1]};
    chk("sump free", 32'(x), 32'h7);
    apb(1'b1, 8'h00, 32'h6);
    settle();
    x = {1'b0, blower_relay, pump_relay, lv[1]};
    chk("sump ilk", 32'(x), 32'h1);
    blow_pos <= 2'h0;
    settle();
    chk("sump off", 32'(lv[1]), 32'h1);
    sens[1] <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    blow_pos <= 2'h2;
    settle();
    pump_pos <= 2'h1;
    k = 0;
    repeat (40)
    begin
      @(posedge pclk);
      k += (clear_cmd === 1'b1);
    end
    chk("clear pulses", 32'(k), 32'h1);
    watch(0, 1200);
    chk("alarm fast", 32'(m), 32'h1);
    repeat (1500) @(posedge pclk);
    watch(0, 1200);
    chk("alarm done", 32'(m), 32'h0);
    pump_pos <= 2'h3;
    blow_pos <= 2'h3;
    watch(10, 4200);
    chk("pump sel fail", 32'({m, pump_relay}), 32'h2);
    watch(8, 4200);
    chk("blow sel fail", 32'({m, blower_relay}), 32'h2);
    for (int s = 0; s < 3; s++)
    begin
      st <= 3'(4 >> s);
      settle();
      watch(s ? 11 : 12, 4200);
      chk("status lamp", 32'(m), s == 1 ? 32'h2 : 32'h1);
    end
    test_done();
  end

endmodule

`default_nettype wire
